// ### dv/flash_programmer.sv
// Purpose: programming-port master model for the flash protection gate
// Assumes: called just after a rising edge of sys_clk
// Notes: released lines show the inverse of the last value
`timescale 1ns/100ps
module flash_programmer (
    input wire logic sys_clk,
    output logic req,
    output logic [1:0] op,
    output logic [15:0] addr,
    output logic page3
);
    initial begin
        req = 1'b0;
        op = 2'h0;
        addr = 16'h0000;
        page3 = 1'b0;
    end

    task automatic send(input logic [1:0] o, input logic [15:0] a, input logic p);
        req <= 1'b1;
        op <= o;
        addr <= a;
        page3 <= p;
        @(posedge sys_clk);
        // stale values must never look like a request
        req <= 1'b0;
        op <= ~o;
        addr <= ~a;
        page3 <= ~p;
    endtask
endmodule

// ### dv/flash_protect_tb_top.sv
// Purpose: random and corner tests of the protection gate and option shadow
// Assumes: wishbone answers within the timeout; port answers one cycle on
// Notes: expectations come from the protect bits sampled at load, then from all ones after a mass erase
`timescale 1ns/100ps
module flash_protect_tb_top;
    logic sys_clk, reset, mass_erase_done, wb_we_i, wb_cyc_i, wb_stb_i;
    logic [7:0] option_byte1;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
    logic [3:0] wb_sel_i;
    logic [1:0] sop, bop, prot;
    logic [15:0] sad, bad;
    logic sreq, breq, sp3, bp3, wb_ack_o, s_g, s_d, b_g, b_d, m_bit, l_bit;
    int n_mismatch, checks, cyc_cnt;
    logic [7:0] opt, d;

    flash_programmer sp (.sys_clk(sys_clk), .req(sreq), .op(sop), .addr(sad), .page3(sp3));
    flash_programmer bp (.sys_clk(sys_clk), .req(breq), .op(bop), .addr(bad), .page3(bp3));
    flash_protect DUT (.sys_clk(sys_clk), .reset(reset), .option_byte1(option_byte1),
        .mass_erase_done(mass_erase_done), .serial_req(sreq), .serial_op(sop),
        .serial_addr(sad), .serial_page3(sp3), .byte_req(breq), .byte_op(bop),
        .byte_addr(bad), .byte_page3(bp3), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_grant(s_g), .serial_deny(s_d),
        .byte_grant(b_g), .byte_deny(b_d), .main_memory_protect_bit(m_bit),
        .lower_half_protect_bit(l_bit), .undivided_clock_select(), .stack16_enable());

    ////////////////////////////////////////////////////////////////////////
    function automatic logic exp_ok(input logic [1:0] o, input logic hi, input logic p);
        // page 3 is guarded even against a mass erase request aimed at it
        if (p) return (o == 2'h0) ? 1'b1 : (prot[0] & prot[1]);
        if (o == 2'h3) return 1'b1;
        if (hi || o == 2'h2) return prot[0];
        return prot[0] & prot[1];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [13:0] a, input logic [7:0] dt);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {18'h00000, a};
        wb_dat_i <= {24'h000000, dt};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic burst(input int n);
        logic [1:0] o;
        logic [15:0] a;
        logic p;
        repeat (n) begin
            o = 2'($urandom);
            a = 16'($urandom);
            p = ($urandom % 4) == 0;
            fork
                sp.send(o, a, p);
                bp.send(o, a ^ 16'h8000, p);
            join
            // answers stand for one cycle only, so look while they are up
            #1;
            chk({s_g, s_d}, {exp_ok(o, a[15], p), !exp_ok(o, a[15], p)});
            chk({b_g, b_d}, {exp_ok(o, !a[15], p), !exp_ok(o, !a[15], p)});
            @(posedge sys_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        {reset, mass_erase_done, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h00;
        {option_byte1, wb_adr_i, wb_dat_i} = 72'h0;
        wb_sel_i = 4'h1;
        void'($urandom(36110));
        for (int k = 0; k < 6; k++) begin
            opt = {4'hF, 2'($urandom), 2'(k)};
            option_byte1 <= opt;
            reset <= 1'b1;
            repeat (6) @(posedge sys_clk);
            chk({m_bit, l_bit}, 2'h0);
            reset <= 1'b0;
            repeat (6) @(posedge sys_clk);
            option_byte1 <= ~opt;
            prot = opt[1:0];
            chk({l_bit, m_bit}, prot);
            wb(1'b0, prot_pkg::opt1_shadow_addr, 8'h00);
            chk(q, {28'h0000000, opt[3:0]});
            d = 8'($urandom);
            wb(1'b1, prot_pkg::opt1_shadow_addr, d);
            wb(1'b0, prot_pkg::opt1_shadow_addr, 8'h00);
            chk(q, {28'h0000000, d[3:2], prot});
            wb(1'b0, 14'h0100, 8'h00);
            chk(q, 32'h00000000);
            burst(16);
            if (k % 2 == 1) begin
                mass_erase_done <= 1'b1;
                @(posedge sys_clk);
                mass_erase_done <= 1'b0;
                repeat (2) @(posedge sys_clk);
                prot = 2'h3;
                chk({l_bit, m_bit}, prot);
                burst(8);
            end
        end
        results();
    end
endmodule

// ### logic/flash_protect.sv
// Purpose: option byte 1 shadow register and protection gate for both programming ports
// Assumes: option byte value stable during reset; flash signals done on sys_clk
// Notes: port requests are single-cycle pulses, answered next cycle
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module flash_protect #(
    parameter int addr_w = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] option_byte1,
    input wire logic mass_erase_done,
    input wire logic serial_req,
    input wire logic [1:0] serial_op,
    input wire logic [addr_w-1:0] serial_addr,
    input wire logic serial_page3,
    input wire logic byte_req,
    input wire logic [1:0] byte_op,
    input wire logic [addr_w-1:0] byte_addr,
    input wire logic byte_page3,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic serial_grant,
    output logic serial_deny,
    output logic byte_grant,
    output logic byte_deny,
    output logic main_memory_protect_bit,
    output logic lower_half_protect_bit,
    output logic undivided_clock_select,
    output logic stack16_enable
);
    ////////////////////////////////////////////////////////////////
    logic [1:0] prot_r;
    logic [1:0] prot_nxt;
    logic [1:0] cfg_r;
    logic [1:0] cfg_nxt;
    logic [2:0] load_cnt_r;
    logic [2:0] load_cnt_nxt;
    logic loaded_r;
    logic loaded_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic ack_r;
    logic ack_nxt;
    logic hit_opt;
    logic hit_stat;
    logic [7:0] shadow_view;

    always_comb begin
        shadow_view = {4'h0, cfg_r, prot_r};
        hit_opt = wb_adr_i[13:0] == prot_pkg::opt1_shadow_addr && wb_adr_i[31:14] == 18'h0;
        hit_stat = wb_adr_i[13:0] == prot_pkg::status_addr && wb_adr_i[31:14] == 18'h0;
        prot_nxt = prot_r;
        cfg_nxt = cfg_r;
        load_cnt_nxt = load_cnt_r;
        loaded_nxt = loaded_r;
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = 32'h0;
        if (!loaded_r) begin
            // sample on the fourth cycle after reset is released so the option byte has settled
            if (load_cnt_r == 3'(prot_pkg::load_cycles - 1)) begin
                prot_nxt = option_byte1[1:0];
                cfg_nxt = option_byte1[3:2];
                loaded_nxt = 1'b1;
            end else begin
                load_cnt_nxt = load_cnt_r + 3'h1;
            end
        end else if (mass_erase_done) begin
            // mass erase opens the shadow copy only
            prot_nxt = 2'h3;
        end
        if (ack_nxt && hit_opt) begin
            dat_nxt = {24'h0, shadow_view};
            if (wb_we_i && wb_sel_i[0] && loaded_r) cfg_nxt = wb_dat_i[3:2];
        end else if (ack_nxt && hit_stat) begin
            dat_nxt = {31'h0, loaded_r};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prot_r <= 2'h0;
            cfg_r <= prot_pkg::ctl_bits_reset;
            load_cnt_r <= 3'h0;
            loaded_r <= 1'b0;
            dat_r <= 32'h0;
            ack_r <= 1'b0;
        end else begin
            prot_r <= prot_nxt;
            cfg_r <= cfg_nxt;
            load_cnt_r <= load_cnt_nxt;
            loaded_r <= loaded_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        wb_dat_o = dat_r;
        wb_ack_o = ack_r;
        main_memory_protect_bit = prot_r[prot_pkg::main_bit_pos];
        lower_half_protect_bit = prot_r[prot_pkg::lower_bit_pos];
        undivided_clock_select = cfg_r[prot_pkg::divby_bit_pos - 2];
        stack16_enable = cfg_r[prot_pkg::stack_bit_pos - 2];
    end

    // both ports share one gate design; nothing passes before loading
    prot_gate #(.addr_w(addr_w)) serial_gate (
        .sys_clk(sys_clk), .reset(reset), .req(serial_req && loaded_r), .op(serial_op),
        .addr(serial_addr), .info_page3(serial_page3), .main_ok(prot_r[0]),
        .lower_ok(prot_r[1]), .grant_r(serial_grant), .deny_r(serial_deny));
    prot_gate #(.addr_w(addr_w)) byte_gate (
        .sys_clk(sys_clk), .reset(reset), .req(byte_req && loaded_r), .op(byte_op),
        .addr(byte_addr), .info_page3(byte_page3), .main_ok(prot_r[0]),
        .lower_ok(prot_r[1]), .grant_r(byte_grant), .deny_r(byte_deny));

    ////////////////////////////////////////////////////////////////
    a_erase_opens: assert property (@(posedge sys_clk) disable iff (reset)
        loaded_r && mass_erase_done |=> prot_r == 2'h3) else $error("erase left protection");
    a_cpu_no_write: assert property (@(posedge sys_clk) disable iff (reset)
        loaded_r && !mass_erase_done |=> prot_r == $past(prot_r)) else $error("prot changed");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack_o |-> wb_dat_o[31:4] == 28'h0) else $error("reserved bits nonzero");
    a_main_blocks: assert property (@(posedge sys_clk) disable iff (reset)
        byte_req && loaded_r && !prot_r[0] && !byte_page3 && byte_op == prot_pkg::op_read
        |=> byte_deny) else $error("main read passed");
    a_open_grants: assert property (@(posedge sys_clk) disable iff (reset)
        serial_req && loaded_r && prot_r == 2'h3 |=> serial_grant) else $error("open denied");
    a_after_erase: assert property (@(posedge sys_clk) disable iff (reset)
        loaded_r && mass_erase_done ##1 byte_req |=> byte_grant) else $error("no access");
    a_sample_load: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(loaded_r) |-> prot_r == $past(option_byte1[1:0])) else $error("bad sample");
    a_lower_gate: assert property (@(posedge sys_clk) disable iff (reset)
        serial_req && loaded_r && !prot_r[1] && !serial_addr[addr_w-1] && !serial_page3
        && serial_op == prot_pkg::op_write |=> serial_deny) else $error("lower write passed");
    a_page3_guard: assert property (@(posedge sys_clk) disable iff (reset)
        byte_req && loaded_r && !prot_r[1] && byte_page3 && byte_op == prot_pkg::op_write
        |=> byte_deny) else $error("page3 write passed");
endmodule

// ### logic/prot_gate.sv
// Purpose: decides whether one programming-port request may reach the flash
// Assumes: requests arrive on sys_clk; result is registered one cycle later
// Notes: upper half is guarded by the whole-memory bit only
`timescale 1ns/100ps
module prot_gate #(
    parameter int addr_w = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic [1:0] op,
    input wire logic [addr_w-1:0] addr,
    input wire logic info_page3,
    input wire logic main_ok,
    input wire logic lower_ok,
    output logic grant_r,
    output logic deny_r
);
    if (addr_w < 2) begin : g_bad_addr_w
        $error("addr_w too small");
    end

    logic ok;
    logic grant_nxt;
    logic deny_nxt;
    logic lower_half;

    always_comb begin
        lower_half = ~addr[addr_w-1];
        ok = 1'b1;
        if (info_page3) begin
            // page 3 writes and erases guarded
            if (op != prot_pkg::op_read && (!main_ok || !lower_ok)) ok = 1'b0;
        end else if (op == prot_pkg::op_mass_erase) begin
            // mass erase outside page 3 is always allowed: it is the way out of protection
            ok = 1'b1;
        end else begin
            if (!main_ok) ok = 1'b0;
            if (lower_half && !lower_ok && op != prot_pkg::op_page_erase) ok = 1'b0;
        end
        grant_nxt = req && ok;
        deny_nxt = req && !ok;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            grant_r <= 1'b0;
            deny_r <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            deny_r <= deny_nxt;
        end
    end

    // lower half reads blocked when lower bit clear
    a_lower_blocked: assert property (@(posedge sys_clk) disable iff (reset)
        req && info_page3 == 1'b0 && !addr[addr_w-1] && !lower_ok
        && op == prot_pkg::op_read |=> deny_r && !grant_r) else $error("lower half read passed");
endmodule

// ### logic/prot_pkg.sv
// Purpose: constants shared by the flash protection gate and its option shadow
// Assumes: one clock, synchronous active-high reset, classic Wishbone with 32-bit data
// Notes: protect bits read 1 when access is allowed, 0 when guarded
// Function
// - lower-half bit 1: lower half open only while whole-memory bit is also 1
// - lower-half bit 0: block lower-half reads/writes, page 3 writes/erases, until mass erase
// - whole-memory bit 1: main flash and page 3 open to both ports except where the lower-half bit 0 guards them
// - whole-memory bit 0: block main flash and page 3 writes unless mass erase done
// - mass erase completion sets shadow protect bits to 1, stored option byte untouched
// - after mass erase both ports get full access, including clearing stored option
// - reserved shadow bits read 0 and ignore cpu writes
// - at power-on reset option byte bits 1 and 0 sampled into flip-flops
// - cpu reads the sampled protect flip-flops but cannot overwrite them
package prot_pkg;
    localparam logic [11:0] opt1_shadow_index = 12'hD0F;
    localparam logic [13:0] opt1_shadow_addr = {opt1_shadow_index, 2'b00};
    localparam logic [13:0] status_addr = 14'h3440;
    localparam int main_bit_pos = 0;
    localparam int lower_bit_pos = 1;
    localparam int divby_bit_pos = 2;
    localparam int stack_bit_pos = 3;
    localparam logic [1:0] ctl_bits_reset = 2'h1;
    localparam logic [7:0] reserved_mask = 8'hF0;
    localparam int load_cycles = 4;

    typedef enum logic [1:0] {op_read, op_write, op_page_erase, op_mass_erase} flash_op_e;
endpackage
